/* sece_consts.svh */
// constants for the serial eeprom command engine
`ifndef SECE_CONSTS_SVH
`define SECE_CONSTS_SVH

// ----------------------------------------
// opcodes
// ----------------------------------------
`define SECE_OP_STATUS_WRITE 8'h01
`define SECE_OP_READ 8'h03
`define SECE_OP_CLR_WEL 8'h04
`define SECE_OP_STATUS_READ 8'h05
`define SECE_OP_SET_WEL 8'h06
`define SECE_OP_WRITE 8'h0B
`define SECE_OP_FAST_READ 8'h0C
`define SECE_OP_PAGE_ERASE 8'h42
`define SECE_OP_POWER_DOWN 8'hB9
`define SECE_OP_IGNORED 8'hFF

// ----------------------------------------
// status register layout
// ----------------------------------------
`define SECE_ST_BUSY 0
`define SECE_ST_WEL 1
`define SECE_ST_BP_LO 2
`define SECE_ST_BP_HI 3
`define SECE_ST_LOWPOWER_STANDBY_ENABLE 5
`define SECE_ST_AUTO_SLEEP_ENABLE 6
`define SECE_ST_LOCK 7
`define SECE_ST_NV_MASK 8'hEC
`define SECE_ST_NV_RESET 8'h00

// ----------------------------------------
// frame layout, in whole bytes received
// ----------------------------------------
`define SECE_BYTES_OPCODE 3'h1
`define SECE_BYTES_STATUS 3'h2
`define SECE_BYTES_ADDR 3'h3
`define SECE_BYTES_DUMMY 3'h4
`define SECE_BYTES_WRDATA 3'h4
`define SECE_LAST_BIT 3'h7

// ----------------------------------------
// geometry and timing
// ----------------------------------------
`define SECE_PAGE_BYTES 128
`define SECE_ADDR_BITS 16
`define SECE_ERASED_BYTE 8'hFF
`define SECE_CLK_PERIOD_NS 10
`define SECE_PROG_TIME_NS 20000
`define SECE_PROG_CYCLES ((`SECE_PROG_TIME_NS + `SECE_CLK_PERIOD_NS - 1) / `SECE_CLK_PERIOD_NS)

`endif

/* sece_pkg.sv */
// types shared by the serial eeprom command engine
package sece_pkg;
  typedef logic [7:0] sece_byte_t;
  typedef enum logic [1:0] {
    SECE_IDLE,
    SECE_COMMIT,
    SECE_SETTLE
  } sece_eng_t;
endpackage

/* sece_core.sv */
// serial eeprom command engine: spi front end, status register, page program and erase
//
// Behaviour
// RULE1 - reset clears the write enable latch.
// RULE2 - program and erase run only with the write enable latch set.
// RULE3 - clear-latch, write, page erase, power-down completion clear the latch.
// RULE4 - frame not a whole number of bytes is dropped, latch untouched.
// RULE5 - clear-latch command works regardless of write-protect pin.
// RULE6 - status read shifts out status including busy and latch flags.
// RULE7 - opcode 01h writes the status byte that follows.
// RULE8 - status write changes only the five non-volatile bits.
// RULE9 - lock bit cannot be cleared while protect pin low and lock set.
// RULE10 - opcode 03h is the normal read.
// RULE11 - host sends full two address bytes after read opcode.
// RULE12 - after address, input ignored and data shifted out msb first.
// RULE13 - reads auto-increment the address and wrap to zero.
// RULE14 - fast read skips one dummy byte before data.
// RULE15 - opcode 0Bh is page write with address and data bytes.
// RULE16 - host ends write-enable frame before starting program frame.
// RULE17 - chip select rising after last data bit starts internal write.
// RULE18 - while busy only status read is served.
// RULE19 - status bit 0 shows busy while program or erase runs.
// RULE20 - write increments only low seven address bits, wrapping in page.
// RULE21 - last 128 bytes kept; unsent bytes of page unchanged.
// RULE22 - write without latch is discarded at chip select rise.
// RULE23 - page erase sets the addressed page to all ones.
// RULE24 - page erase ignores the seven low address bits.
// RULE25 - status writable unless protect pin low and lock bit set.
// RULE26 - block protect codes guard none, top quarter, top half, all.
// RULE27 - status layout busy, latch, bp0, bp1, zero, lowpower_standby_enable, auto_sleep_enable, lock.
// RULE28 - input sampled on rising sck, output changed on falling, msb first.
// RULE29 - writes and erases into the protected region are refused.
`timescale 1ns/100ps
`default_nettype none
`include "sece_consts.svh"

module sece_core #(
  parameter int MEM_ADDR_W = `SECE_ADDR_BITS,
  parameter int PAGE_BYTES = `SECE_PAGE_BYTES,
  parameter int PROG_CYCLES = `SECE_PROG_CYCLES
) (
  input wire logic clk,                          // system clock
  input wire logic rst_b,                        // power-up reset
  input wire logic sck,                          // serial clock from host
  input wire logic chipSel_b,                    // chip select pin
  input wire logic serialIn,                     // serial data in
  output logic serialOut,                        // serial data out
  output logic serialOutEn_b,                    // serial out enable
  input wire logic writeProtect_b,               // write protect pin
  output logic busyFlag,                         // internal cycle running
  output logic writeEnableLatch,                 // latch state
  output logic autoSleepEnable,                  // auto power-down enable
  output logic lowpowerStandbyEnable,            // low-power standby enable
  output sece_pkg::sece_byte_t statusView        // whole status byte
);
  import sece_pkg::*;

  localparam int PAGE_W = $clog2(PAGE_BYTES);
  localparam int MEM_BYTES = 1 << MEM_ADDR_W;

  generate
    if (MEM_ADDR_W < 8 || MEM_ADDR_W > `SECE_ADDR_BITS || PAGE_BYTES != (1 << PAGE_W) ||
        PAGE_W >= MEM_ADDR_W || PROG_CYCLES < 1) begin : g_badParams
      $error("sece_core: unsupported geometry or timing parameters");
    end
  endgenerate

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic isProtected(input logic [1:0] bp, input logic [1:0] top);
    case (bp)
      2'h0: isProtected = 1'b0;
      2'h1: isProtected = (top == 2'h3);
      2'h2: isProtected = top[1];
      default: isProtected = 1'b1;
    endcase
  endfunction

  function automatic logic isSendPhase(input sece_byte_t op, input logic [2:0] bytes);
    case (op)
      `SECE_OP_READ: isSendPhase = (bytes >= `SECE_BYTES_ADDR);
      `SECE_OP_FAST_READ: isSendPhase = (bytes >= `SECE_BYTES_DUMMY);
      `SECE_OP_STATUS_READ: isSendPhase = (bytes >= `SECE_BYTES_OPCODE);
      default: isSendPhase = 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // storage
  // ----------------------------------------
  sece_byte_t memArray [0:MEM_BYTES-1];
  sece_byte_t pageBuf [0:PAGE_BYTES-1];

  // sck domain state
  logic fresh_ff;
  logic [2:0] bitCnt_ff;
  logic [2:0] byteCnt_ff;
  logic [6:0] rxShift_ff;
  sece_byte_t opcode_ff;
  sece_byte_t addrHi_ff;
  sece_byte_t statusData_ff;
  logic [`SECE_ADDR_BITS-1:0] addr_ff;
  logic [PAGE_BYTES-1:0] pageMask_ff;
  logic frameTog_ff;
  sece_byte_t statusMeta_ff;
  sece_byte_t statusSck_ff;
  sece_byte_t txShift_ff;

  // clk domain state
  logic csMeta_ff, csSync_ff, csPrev_ff;
  logic wpMeta_ff, wpSync_ff;
  logic togMeta_ff, togSync_ff, togSeen_ff;
  logic wel_ff;
  sece_byte_t nvStatus_ff;
  sece_eng_t eng_ff;
  logic [PAGE_W-1:0] engIdx_ff;
  logic engErase_ff;
  logic [MEM_ADDR_W-PAGE_W-1:0] engPage_ff;
  logic [31:0] settle_ff;

  // ----------------------------------------
  // sck domain: frame reception
  // ----------------------------------------
  logic [2:0] bitIdx;
  logic [2:0] byteIdx;
  logic byteDone;
  sece_byte_t rxByte;
  logic busySck;
  logic sendPhase;
  logic [PAGE_W-1:0] wrOffset;

  assign bitIdx = fresh_ff ? 3'h0 : bitCnt_ff;
  assign byteIdx = fresh_ff ? 3'h0 : byteCnt_ff;
  assign byteDone = (bitIdx == `SECE_LAST_BIT);
  assign rxByte = {rxShift_ff, serialIn};
  assign busySck = statusSck_ff[`SECE_ST_BUSY];
  assign sendPhase = !fresh_ff && isSendPhase(opcode_ff, byteCnt_ff);
  assign wrOffset = addr_ff[PAGE_W-1:0];

  // raised by chip select high, so the next frame restarts its counters at its first edge
  always_ff @(posedge sck or negedge rst_b or posedge chipSel_b) begin
    if (!rst_b) begin
      fresh_ff <= 1'b1;
    end else if (chipSel_b) begin
      fresh_ff <= 1'b1;
    end else begin
      fresh_ff <= 1'b0;
    end
  end

  always_ff @(posedge sck or negedge rst_b) begin
    if (!rst_b) begin
      bitCnt_ff <= 3'h0;
      byteCnt_ff <= 3'h0;
      rxShift_ff <= 7'h00;
    end else begin
      rxShift_ff <= {rxShift_ff[5:0], serialIn}; // RULE28
      bitCnt_ff <= bitIdx + 3'h1;
      if (byteDone && byteIdx != 3'h7) begin
        byteCnt_ff <= byteIdx + 3'h1;
      end else begin
        byteCnt_ff <= byteIdx;
      end
    end
  end

  // one toggle per frame lets the clk side tell a real frame from a bare chip select pulse
  always_ff @(posedge sck or negedge rst_b) begin
    if (!rst_b) begin
      frameTog_ff <= 1'b0;
    end else if (fresh_ff) begin
      frameTog_ff <= ~frameTog_ff;
    end
  end

  always_ff @(posedge sck or negedge rst_b) begin
    if (!rst_b) begin
      opcode_ff <= `SECE_OP_IGNORED;
      addrHi_ff <= 8'h00;
      statusData_ff <= 8'h00;
    end else if (byteDone && byteIdx == 3'h0) begin
      if (busySck && rxByte != `SECE_OP_STATUS_READ) begin
        opcode_ff <= `SECE_OP_IGNORED; // RULE18
      end else begin
        opcode_ff <= rxByte; // RULE7 RULE10 RULE15
      end
    end else if (byteDone && byteIdx == 3'h1) begin
      addrHi_ff <= rxByte;
      statusData_ff <= rxByte;
    end
  end

  // one pointer serves reads (full increment) and writes (page-local increment)
  always_ff @(posedge sck or negedge rst_b) begin
    if (!rst_b) begin
      addr_ff <= '0;
    end else if (byteDone && byteIdx == 3'h2) begin
      addr_ff <= {addrHi_ff, rxByte}; // RULE11
    end else if (byteDone && sendPhase && opcode_ff != `SECE_OP_STATUS_READ) begin
      if (addr_ff[MEM_ADDR_W-1:0] == MEM_ADDR_W'(MEM_BYTES - 1)) begin
        addr_ff <= '0; // RULE13
      end else begin
        addr_ff <= addr_ff + 16'h0001; // RULE13
      end
    end else if (byteDone && byteIdx >= `SECE_BYTES_ADDR && opcode_ff == `SECE_OP_WRITE) begin
      addr_ff[PAGE_W-1:0] <= wrOffset + PAGE_W'(1); // RULE20
    end
  end

  always_ff @(posedge sck or negedge rst_b) begin
    if (!rst_b) begin
      pageMask_ff <= '0;
    end else if (byteDone && byteIdx == 3'h0 && rxByte == `SECE_OP_WRITE && !busySck) begin
      pageMask_ff <= '0; // a running commit still reads the old mask
    end else if (byteDone && byteIdx >= `SECE_BYTES_ADDR && opcode_ff == `SECE_OP_WRITE) begin
      pageMask_ff[wrOffset] <= 1'b1; // RULE21
    end
  end

  // later bytes landing on the same offset overwrite, so only the last page-full survives
  always_ff @(posedge sck) begin
    if (byteDone && byteIdx >= `SECE_BYTES_ADDR && opcode_ff == `SECE_OP_WRITE) begin
      pageBuf[wrOffset] <= rxByte; // RULE21
    end
  end

  // status bits are independent levels, each through two stages
  always_ff @(posedge sck or negedge rst_b) begin
    if (!rst_b) begin
      statusMeta_ff <= 8'h00;
      statusSck_ff <= 8'h00;
    end else begin
      statusMeta_ff <= statusView;
      statusSck_ff <= statusMeta_ff;
    end
  end

  // ----------------------------------------
  // sck domain: transmit on falling edges
  // ----------------------------------------
  // the array is only read while idle, so its words are steady across this domain
  always_ff @(negedge sck or negedge rst_b) begin
    if (!rst_b) begin
      txShift_ff <= 8'h00;
    end else if (sendPhase && bitCnt_ff == 3'h0) begin
      if (opcode_ff == `SECE_OP_STATUS_READ) begin
        txShift_ff <= statusSck_ff; // RULE6
      end else begin
        txShift_ff <= memArray[addr_ff[MEM_ADDR_W-1:0]]; // RULE12 RULE14
      end
    end else begin
      txShift_ff <= {txShift_ff[6:0], 1'b0}; // RULE28
    end
  end

  assign serialOut = txShift_ff[7];
  assign serialOutEn_b = chipSel_b;

  // ----------------------------------------
  // clk domain: pin and frame synchronisers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      csMeta_ff <= 1'b1;
      csSync_ff <= 1'b1;
      csPrev_ff <= 1'b1;
      wpMeta_ff <= 1'b0;
      wpSync_ff <= 1'b0;
      togMeta_ff <= 1'b0;
      togSync_ff <= 1'b0;
    end else begin
      csMeta_ff <= chipSel_b;
      csSync_ff <= csMeta_ff;
      csPrev_ff <= csSync_ff;
      wpMeta_ff <= writeProtect_b;
      wpSync_ff <= wpMeta_ff;
      togMeta_ff <= frameTog_ff;
      togSync_ff <= togMeta_ff;
    end
  end

  // frame fields below are read only after chip select is high, when sck is still
  logic csRise;
  logic commit;
  logic whole;
  logic idle;
  logic latchOk;
  logic pageLocked;
  logic srWritable;
  logic startWrite;
  logic startErase;

  assign csRise = csSync_ff && !csPrev_ff;
  assign commit = csRise && (togSync_ff != togSeen_ff);
  assign whole = (bitCnt_ff == 3'h0); // RULE4
  assign idle = (eng_ff == SECE_IDLE);
  assign latchOk = commit && whole && idle && wel_ff; // RULE2 RULE22
  assign pageLocked = isProtected({nvStatus_ff[`SECE_ST_BP_HI], nvStatus_ff[`SECE_ST_BP_LO]},
                                  addr_ff[MEM_ADDR_W-1 -: 2]); // RULE26
  assign srWritable = wpSync_ff || !nvStatus_ff[`SECE_ST_LOCK]; // RULE9 RULE25
  assign startWrite = latchOk && opcode_ff == `SECE_OP_WRITE &&
                      byteCnt_ff >= `SECE_BYTES_WRDATA && !pageLocked; // RULE17 RULE29
  assign startErase = latchOk && opcode_ff == `SECE_OP_PAGE_ERASE &&
                      byteCnt_ff >= `SECE_BYTES_ADDR && !pageLocked; // RULE23 RULE29

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      togSeen_ff <= 1'b0;
    end else if (csRise) begin
      togSeen_ff <= togSync_ff;
    end
  end

  // ----------------------------------------
  // clk domain: write enable latch
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wel_ff <= 1'b0; // RULE1
    end else if (commit && whole && idle) begin
      case (opcode_ff)
        `SECE_OP_SET_WEL: wel_ff <= 1'b1;
        `SECE_OP_CLR_WEL: wel_ff <= 1'b0; // RULE5
        `SECE_OP_POWER_DOWN: wel_ff <= 1'b0; // RULE3
        `SECE_OP_STATUS_WRITE: begin
          if (byteCnt_ff >= `SECE_BYTES_STATUS && srWritable) begin
            wel_ff <= 1'b0;
          end
        end
        `SECE_OP_WRITE: begin
          if (byteCnt_ff >= `SECE_BYTES_WRDATA) begin
            wel_ff <= 1'b0; // RULE3
          end
        end
        `SECE_OP_PAGE_ERASE: begin
          if (byteCnt_ff >= `SECE_BYTES_ADDR) begin
            wel_ff <= 1'b0; // RULE3
          end
        end
        default: wel_ff <= wel_ff;
      endcase
    end
  end

  // ----------------------------------------
  // clk domain: non-volatile status bits
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      nvStatus_ff <= `SECE_ST_NV_RESET;
    end else if (latchOk && opcode_ff == `SECE_OP_STATUS_WRITE &&
                 byteCnt_ff >= `SECE_BYTES_STATUS && srWritable) begin
      nvStatus_ff <= (nvStatus_ff & ~`SECE_ST_NV_MASK) | (statusData_ff & `SECE_ST_NV_MASK); // RULE8
    end
  end

  // ----------------------------------------
  // clk domain: self-timed program and erase
  // ----------------------------------------
  // walk the whole page once, then hold busy for the settle time
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      eng_ff <= SECE_IDLE;
      engIdx_ff <= '0;
      engErase_ff <= 1'b0;
      engPage_ff <= '0;
      settle_ff <= 32'h0;
    end else begin
      case (eng_ff)
        SECE_IDLE: begin
          if (startWrite || startErase) begin
            eng_ff <= SECE_COMMIT; // RULE17
            engIdx_ff <= '0;
            engErase_ff <= startErase;
            engPage_ff <= addr_ff[MEM_ADDR_W-1:PAGE_W]; // RULE24
          end
        end
        SECE_COMMIT: begin
          engIdx_ff <= engIdx_ff + PAGE_W'(1);
          if (engIdx_ff == PAGE_W'(PAGE_BYTES - 1)) begin
            eng_ff <= SECE_SETTLE;
            settle_ff <= 32'(PROG_CYCLES - 1);
          end
        end
        SECE_SETTLE: begin
          if (settle_ff == 32'h0) begin
            eng_ff <= SECE_IDLE;
          end else begin
            settle_ff <= settle_ff - 32'h1;
          end
        end
        default: eng_ff <= SECE_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (eng_ff == SECE_COMMIT) begin
      if (engErase_ff) begin
        memArray[{engPage_ff, engIdx_ff}] <= `SECE_ERASED_BYTE; // RULE23
      end else if (pageMask_ff[engIdx_ff]) begin
        memArray[{engPage_ff, engIdx_ff}] <= pageBuf[engIdx_ff]; // RULE21
      end
    end
  end

  // ----------------------------------------
  // status outputs
  // ----------------------------------------
  always_comb begin
    statusView = nvStatus_ff & `SECE_ST_NV_MASK; // RULE27
    statusView[`SECE_ST_BUSY] = !idle; // RULE19
    statusView[`SECE_ST_WEL] = wel_ff;
  end

  assign busyFlag = !idle;
  assign writeEnableLatch = wel_ff;
  assign autoSleepEnable = nvStatus_ff[`SECE_ST_AUTO_SLEEP_ENABLE];
  assign lowpowerStandbyEnable = nvStatus_ff[`SECE_ST_LOWPOWER_STANDBY_ENABLE];

endmodule
`default_nettype wire

/* sece_core_chk.sv */
// assertion checker bound to the serial eeprom command engine
`timescale 1ns/100ps
`default_nettype none
module sece_core_chk #(
  parameter int MEM_ADDR_W = 16,
  parameter int PAGE_BYTES = 128,
  parameter int PROG_CYCLES = 2000
) (
  input wire logic clk, // system clock
  input wire logic rst_b, // reset
  input wire logic sck, // link clock
  input wire logic chipSel_b, // select
  input wire logic serialIn, // data in
  input wire logic serialOut, // data out
  input wire logic serialOutEn_b, // out enable
  input wire logic writeProtect_b, // protect pin
  input wire logic busyFlag, // busy
  input wire logic writeEnableLatch, // latch
  input wire logic autoSleepEnable, // status bit 6
  input wire logic lowpowerStandbyEnable, // status bit 5
  input wire sece_pkg::sece_byte_t statusView // status byte
);
  import sece_pkg::*;
  localparam int BUSY_LEN = PAGE_BYTES + PROG_CYCLES;
  int busyCnt_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busyCnt_ff <= 0;
    end else begin
      busyCnt_ff <= busyFlag ? busyCnt_ff + 1 : 0;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  chk_view_busy: assert property (statusView[0] == busyFlag) else $error("status bit 0 differs from busy");
  chk_view_wel: assert property (statusView[1] == writeEnableLatch) else $error("status bit 1 differs");
  chk_reserved_zero: assert property (statusView[4] == 1'b0) else $error("reserved status bit set");
  chk_view_power: assert property (statusView[6:5] == {autoSleepEnable, lowpowerStandbyEnable})
    else $error("power bits differ from status");
  chk_oe_select: assert property (serialOutEn_b == chipSel_b) else $error("output enable off select");
  chk_wel_framed: assert property ($changed(writeEnableLatch) |-> $past(chipSel_b, 2))
    else $error("latch changed inside a frame");
  chk_busy_latch: assert property ($rose(busyFlag) |-> !writeEnableLatch &&
    ($past(writeEnableLatch, 2) || $past(writeEnableLatch, 3))) else $error("busy without latch");
  chk_busy_bound: assert property (busyCnt_ff <= BUSY_LEN + 2) else $error("busy too long");
  chk_busy_full: assert property ($fell(busyFlag) |-> $past(busyCnt_ff) >= BUSY_LEN - 2)
    else $error("busy too short");
  chk_status_gate: assert property ($changed(statusView[7:2]) |-> $past(chipSel_b, 2) &&
    ($past(writeEnableLatch, 1) || $past(writeEnableLatch, 2))) else $error("status changed without latch");
  chk_lock_pin: assert property ($fell(statusView[7]) |-> $past(writeProtect_b, 3))
    else $error("lock cleared with pin low");
  cover property ($rose(busyFlag));
  cover property ($rose(writeEnableLatch));
  cover property ($changed(statusView[3:2]));
  cover property ($fell(statusView[7]));
endmodule
bind sece_core sece_core_chk #(.MEM_ADDR_W(MEM_ADDR_W), .PAGE_BYTES(PAGE_BYTES), .PROG_CYCLES(PROG_CYCLES)) chk (
  .clk(clk), .rst_b(rst_b), .sck(sck), .chipSel_b(chipSel_b), .serialIn(serialIn), .serialOut(serialOut),
  .serialOutEn_b(serialOutEn_b), .writeProtect_b(writeProtect_b), .busyFlag(busyFlag),
  .writeEnableLatch(writeEnableLatch), .autoSleepEnable(autoSleepEnable),
  .lowpowerStandbyEnable(lowpowerStandbyEnable), .statusView(statusView));
`default_nettype wire

/* sece_host.sv */
// host spi controller model driving the engine's link pins
`timescale 1ns/100ps
`default_nettype none
module sece_host (
  input wire logic clk, // system clock, frames start on it
  input wire logic serialOut, // data from device
  output logic sck, // link clock, still between frames
  output logic chipSel_b, // select, active low
  output logic serialIn // data to device
);
  logic [7:0] txQ[$];
  logic [7:0] rxQ[$];
  initial begin
    sck = 1'b0;
    chipSel_b = 1'b1;
    serialIn = 1'b0;
  end
  // ----------------------------------------
  // one frame, mode 0, 6 ns link period
  // ----------------------------------------
  task automatic frame(input int nbits);
    logic [7:0] b;
    logic [7:0] r;
    rxQ.delete();
    r = 8'h00;
    @(posedge clk);
    chipSel_b <= 1'b0;
    #3;
    for (int i = 0; i < nbits; i++) begin
      // past the queue a 55h/AAh byte pattern whose selected bit is always 0, so dummy and idle bits are sent low
      b = (i / 8 < txQ.size()) ? txQ[i / 8] : {4{i[0], ~i[0]}};
      serialIn = b[7 - i % 8];
      #3 sck = 1'b1;
      r = {r[6:0], serialOut};
      if (i % 8 == 7) rxQ.push_back(r);
      #3 sck = 1'b0;
    end
    #1 chipSel_b = 1'b1;
    serialIn = ~serialIn;
  endtask
endmodule
`default_nettype wire

/* serial_eeprom_command_engine_tb.sv */
// self-checking bench for the serial eeprom command engine
`timescale 1ns/100ps
`default_nettype none
module serial_eeprom_command_engine_tb;
  import sece_pkg::*;
  logic clk;
  logic rst_b;
  logic writeProtect_b;
  logic sck;
  logic chipSel_b;
  logic serialIn;
  logic serialOut;
  logic serialOutEn_b;
  logic busyFlag;
  logic writeEnableLatch;
  logic autoSleepEnable;
  logic lowpowerStandbyEnable;
  sece_byte_t statusView;
  int errors;
  int num_checks;
  logic [7:0] mem [1024];
  logic [7:0] nv;
  logic write_enable_latch;
  logic busyM;
  logic went;
  // small array so the top page and wrap are reachable quickly
  sece_core #(.MEM_ADDR_W(10), .PAGE_BYTES(128), .PROG_CYCLES(4)) dut (
    .clk(clk), .rst_b(rst_b), .sck(sck), .chipSel_b(chipSel_b), .serialIn(serialIn), .serialOut(serialOut),
    .serialOutEn_b(serialOutEn_b), .writeProtect_b(writeProtect_b), .busyFlag(busyFlag),
    .writeEnableLatch(writeEnableLatch), .autoSleepEnable(autoSleepEnable),
    .lowpowerStandbyEnable(lowpowerStandbyEnable), .statusView(statusView));
  sece_host host (.clk(clk), .serialOut(serialOut), .sck(sck), .chipSel_b(chipSel_b), .serialIn(serialIn));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic checkByte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: serial byte %h, model %h", $time, got, exp);
    end
  endtask
  task automatic checkPort(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: port value %h, model %h", $time, got, exp);
    end
  endtask
  function automatic logic prot(input logic [15:0] ad);
    return nv[3:2] == 2'h3 || (nv[3:2] == 2'h2 && ad[9]) || (nv[3:2] == 2'h1 && ad[9:8] == 2'h3);
  endfunction
  // ----------------------------------------
  // frame driver with reference model
  // ----------------------------------------
  task automatic load(input logic [7:0] op, input logic [15:0] ad, input int nd);
    host.txQ = {op, ad[15:8], ad[7:0]};
    repeat (nd) host.txQ.push_back(8'($urandom));
  endtask
  task automatic send(input int nbits);
    logic [7:0] op;
    logic [15:0] ad;
    int n;
    op = host.txQ[0];
    ad = {host.txQ[1], host.txQ[2]} & 16'h03FF;
    n = (op == 8'h42) ? 128 : host.txQ.size() - 3;
    went = 1'b0;
    host.frame(nbits);
    repeat (8) @(posedge clk);
    if (nbits % 8 == 0 && !busyM) begin
      case (op)
        8'h06: write_enable_latch = 1'b1;
        8'h04, 8'hB9: write_enable_latch = 1'b0;
        8'h01: if (write_enable_latch && (writeProtect_b || !nv[7])) begin
          nv = host.txQ[1] & 8'hEC;
          write_enable_latch = 1'b0;
        end
        8'h0B, 8'h42: if (write_enable_latch) begin
          went = !prot(ad);
          for (int i = 0; i < n && went; i++) begin
            mem[{ad[9:7], 7'(ad[6:0] + i)}] = (op == 8'h42) ? 8'hFF : host.txQ[3 + i];
          end
          write_enable_latch = 1'b0;
        end
        default: ;
      endcase
    end
    checkPort(8'(writeEnableLatch), 8'(write_enable_latch));
  endtask
  task automatic st();
    load(8'h05, 16'h0000, 0);
    send(16);
    checkByte(host.rxQ[1], {nv[7:2], write_enable_latch, busyM});
    checkPort(statusView, {nv[7:2], write_enable_latch, busyM});
    checkPort(8'(busyFlag), 8'(busyM));
    checkPort(8'(serialOutEn_b), 8'h01);
    checkPort(8'({autoSleepEnable, lowpowerStandbyEnable}), 8'(nv[6:5]));
  endtask
  task automatic wen();
    load(8'h06, 16'h0000, 0);
    send(8);
  endtask
  task automatic rd(input logic [7:0] op, input logic [15:0] ad, input int nb);
    int h;
    h = (op == 8'h0C) ? 4 : 3;
    load(op, ad, 0);
    send(8 * (h + nb));
    for (int i = 0; i < nb; i++) begin
      checkByte(host.rxQ[h + i], mem[(ad + i) % 1024]);
    end
  endtask
  task automatic prog(input logic [7:0] op, input logic [15:0] ad, input int nd);
    int k;
    logic g;
    load(op, ad, nd);
    send(op == 8'h42 ? 24 : 24 + 8 * nd);
    g = went;
    if (g) begin
      busyM = 1'b1;
      st();
      wen();
    end
    for (k = 0; k < 400 && busyFlag !== 1'b0; k++) @(posedge clk);
    if (k == 400) begin
      errors++;
      $display("mismatch at %0t: busy never ended", $time);
      complete_run();
    end
    busyM = 1'b0;
    if (g) st();
  endtask
  task automatic sw(input logic [7:0] v);
    wen();
    load(8'h01, {v, 8'h00}, 0);
    send(16);
    st();
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_b = 1'b0;
    writeProtect_b = 1'b1;
    errors = 0;
    num_checks = 0;
    nv = 8'h00;
    write_enable_latch = 1'b0;
    busyM = 1'b0;
    went = 1'b0;
    void'($urandom(45526));
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    st();
    load(8'h06, 16'h0000, 0);
    send(7);
    wen();
    load(8'h04, 16'h0000, 0);
    send(12);
    writeProtect_b <= 1'b0;
    load(8'h04, 16'h0000, 0);
    send(8);
    writeProtect_b <= 1'b1;
    prog(8'h0B, 16'h0090, 2);
    for (int j = 0; j < 3; j++) begin
      wen();
      prog(8'h42, 16'((j == 2 ? 7 : j) * 128 + 42), 0);
    end
    wen();
    prog(8'h0B, 16'h00FE, 130);
    wen();
    prog(8'h0B, 16'h0085, 3);
    rd(8'h03, 16'h0080, 128);
    rd(8'h0C, 16'h03FE, 3);
    for (int b = 0; b < 4; b++) begin
      sw((8'($urandom) & 8'h73) | 8'(b << 2));
      wen();
      prog(8'h0B, 16'h0380, 1);
      wen();
      prog(8'h0B, 16'h00A0, 1);
      rd(8'h03, 16'h0380, 1);
      rd(8'h03, 16'h00A0, 1);
    end
    sw(8'h84);
    writeProtect_b <= 1'b0;
    sw(8'h00);
    writeProtect_b <= 1'b1;
    sw(8'h00);
    wen();
    load(8'hB9, 16'h0000, 0);
    send(8);
    complete_run();
  end
endmodule
`default_nettype wire
